// ### hw/motor_ctrl_regs.sv
// command, control and multiplexed status registers of the motor controller
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - writing 00h to command register restarts watchdog; host must repeat it
// - writing 55h clears checksum driver-off state and its error flag
// - writing FFh releases the protection latch-off of the output stage
// - any other command value has no effect
// - control two bit 7 enables short brake; resets to zero
// - duty input is control one bits 7:0 plus control two bits 1:0
// - selector bits 3:0 at 306h choose the 24-bit status word
// - low byte read captures bits 23:8; host reads low byte first
// - upper bytes keep the captured value until the next low read
// - upper bytes read zero before any low-byte read after reset
// - selector 0 gives 20-bit rotation period, upper bits zero
// - period count steps every two 500 kHz ticks, 4 us each
// - selector 1 gives rpm in bits 14:0
// - selector 2 gives measured 10-bit input duty
// - seed register reads hidden-area checksum
// - seed starts the user-area checksum calculation
// - selectors 3 and 4 give 22-bit input period and high counts
// - selector 5 gives 15-bit control target
// - selector 6 gives 10-bit loop duty result
// - selector 8 gives phase connection flags
module motor_ctrl_regs
  import motor_regs_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [9:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  input wire logic REV_PULSE,
  input wire logic [9:0] IN_DUTY,
  input wire logic [21:0] IN_PERIOD,
  input wire logic [21:0] IN_HIGH,
  input wire logic [14:0] TARGET,
  input wire logic [9:0] LOOP_DUTY,
  input wire logic [2:0] PHASE_OK,
  input wire logic [7:0] HIDDEN_CHECKSUM,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic WATCHDOG_RESTART,
  output logic CHECKSUM_CLEAR,
  output logic LATCH_RELEASE,
  output logic SHORT_BRAKE_ENABLE,
  output logic [9:0] DUTY_INPUT_VALUE,
  output logic [7:0] CHECKSUM_SEED
);
  logic [7:0] duty_low_r;
  logic [7:0] brake_ctl_r;
  logic [3:0] sel_r;
  logic [15:0] hold_r;
  logic [19:0] period_count;
  logic [14:0] speed_rpm;
  logic [23:0] status_word;
  logic wr_cmd;
  logic rd_low;
  logic low_seen_r;

  assign wr_cmd = CE && WR_EN && ADDR == ADDR_CMD;
  assign rd_low = CE && RD_EN && ADDR == ADDR_STAT_LOW;

  period_counter u_period (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .rev_pulse(REV_PULSE),
    .period_count(period_count),
    .speed_rpm(speed_rpm)
  );

  status_mux u_mux (
    .sel(sel_r),
    .period_count(period_count),
    .speed_rpm(speed_rpm),
    .in_duty(IN_DUTY),
    .in_period(IN_PERIOD),
    .in_high(IN_HIGH),
    .target(TARGET),
    .loop_duty(LOOP_DUTY),
    .phase_ok(PHASE_OK),
    .word(status_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command decode: one-cycle pulses, unknown codes ignored
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      WATCHDOG_RESTART <= 1'b0;
      CHECKSUM_CLEAR <= 1'b0;
      LATCH_RELEASE <= 1'b0;
    end else if (CE) begin
      WATCHDOG_RESTART <= wr_cmd && WDATA == CMD_WATCHDOG;
      CHECKSUM_CLEAR <= wr_cmd && WDATA == CMD_CHECKSUM_CLR;
      LATCH_RELEASE <= wr_cmd && WDATA == CMD_LATCH_RELEASE;
    end
  end

  // control registers
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      duty_low_r <= CTRL_RESET;
      brake_ctl_r <= CTRL_RESET;
      sel_r <= 4'h0;
    end else if (CE && WR_EN) begin
      if (ADDR == ADDR_DUTY_LOW) begin
        duty_low_r <= WDATA;
      end
      if (ADDR == ADDR_BRAKE_DUTY_HIGH) begin
        brake_ctl_r <= {WDATA[BRAKE_BIT], 5'h00, WDATA[1:0]};
      end
      if (ADDR == ADDR_STAT_SEL) begin
        sel_r <= WDATA[3:0];
      end
    end
  end

  // registered control outputs
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      SHORT_BRAKE_ENABLE <= 1'b0;
      DUTY_INPUT_VALUE <= 10'h000;
      CHECKSUM_SEED <= 8'h00;
    end else if (CE) begin
      SHORT_BRAKE_ENABLE <= brake_ctl_r[BRAKE_BIT];
      DUTY_INPUT_VALUE <= {brake_ctl_r[1:0], duty_low_r};
      CHECKSUM_SEED <= HIDDEN_CHECKSUM;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upper bytes snapshot; zero until first low-byte read
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      hold_r <= 16'h0000;
    end else if (rd_low) begin
      hold_r <= status_word[23:8];
    end
  end

  // marks a low-byte read since reset; only the zero checks read it
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      low_seen_r <= 1'b0;
    end else if (rd_low) begin
      low_seen_r <= 1'b1;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      RDATA <= 8'h00;
      RVALID <= 1'b0;
    end else if (CE) begin
      RVALID <= RD_EN;
      RDATA <= 8'h00;
      if (RD_EN) begin
        case (ADDR)
          ADDR_STAT_LOW: RDATA <= status_word[7:0];
          ADDR_STAT_MID: RDATA <= hold_r[7:0];
          ADDR_STAT_HIGH: RDATA <= hold_r[15:8];
          ADDR_SEED: RDATA <= CHECKSUM_SEED;
          ADDR_DUTY_LOW: RDATA <= duty_low_r;
          ADDR_BRAKE_DUTY_HIGH: RDATA <= brake_ctl_r;
          ADDR_STAT_SEL: RDATA <= {4'h0, sel_r};
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cmd_wdt;
    @(posedge MCLK) disable iff (RESET)
      wr_cmd && WDATA == CMD_WATCHDOG |=> WATCHDOG_RESTART;
  endproperty
  a_cmd_wdt: assert property (p_cmd_wdt) else $error("watchdog restart missing");

  property p_cmd_csum;
    @(posedge MCLK) disable iff (RESET)
      wr_cmd && WDATA == CMD_CHECKSUM_CLR |=> CHECKSUM_CLEAR && !LATCH_RELEASE;
  endproperty
  a_cmd_csum: assert property (p_cmd_csum) else $error("checksum clear missing");

  property p_cmd_latch;
    @(posedge MCLK) disable iff (RESET)
      wr_cmd && WDATA == CMD_LATCH_RELEASE |=> LATCH_RELEASE && !WATCHDOG_RESTART;
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("latch release missing");

  property p_cmd_other;
    @(posedge MCLK) disable iff (RESET)
      CE && !wr_cmd |=> !WATCHDOG_RESTART && !CHECKSUM_CLEAR && !LATCH_RELEASE;
  endproperty
  a_cmd_other: assert property (p_cmd_other) else $error("spurious command pulse");

  property p_brake;
    @(posedge MCLK) disable iff (RESET)
      CE && WR_EN && ADDR == ADDR_BRAKE_DUTY_HIGH ##1 CE |=>
        SHORT_BRAKE_ENABLE == $past(WDATA[BRAKE_BIT], 2);
  endproperty
  a_brake: assert property (p_brake) else $error("brake enable mismatch");

  property p_duty;
    @(posedge MCLK) disable iff (RESET)
      CE && WR_EN && ADDR == ADDR_DUTY_LOW ##1 CE |=>
        DUTY_INPUT_VALUE[7:0] == $past(WDATA, 2);
  endproperty
  a_duty: assert property (p_duty) else $error("duty low byte mismatch");

  sequence s_low_read;
    rd_low;
  endsequence
  sequence s_mid_read;
    CE && RD_EN && ADDR == ADDR_STAT_MID && !rd_low;
  endsequence
  property p_hold;
    @(posedge MCLK) disable iff (RESET)
      s_low_read ##1 s_mid_read |=> RDATA == $past(status_word[15:8], 2);
  endproperty
  a_hold: assert property (p_hold) else $error("held mid byte incoherent");

  property p_keep;
    @(posedge MCLK) disable iff (RESET)
      !rd_low |=> hold_r == $past(hold_r);
  endproperty
  a_keep: assert property (p_keep) else $error("held bytes changed without low read");

  property p_zero_hi;
    @(posedge MCLK) disable iff (RESET)
      status_word[23:22] == 2'h0 && (sel_r != SEL_PERIOD || status_word[23:20] == 4'h0);
  endproperty
  a_zero_hi: assert property (p_zero_hi) else $error("unused status bits set");

  property p_low_byte;
    @(posedge MCLK) disable iff (RESET)
      rd_low |=> RDATA == $past(status_word[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low status byte mismatch");

  // burst read: low, mid and high on three edges in a row
  sequence s_high_read;
    CE && RD_EN && ADDR == ADDR_STAT_HIGH;
  endsequence
  property p_snap_high;
    @(posedge MCLK) disable iff (RESET)
      s_low_read ##1 s_mid_read ##1 s_high_read |=> RDATA == $past(status_word[23:16], 3);
  endproperty
  a_snap_high: assert property (p_snap_high) else $error("held high byte incoherent");

  property p_zero_mid;
    @(posedge MCLK) disable iff (RESET)
      CE && RD_EN && ADDR == ADDR_STAT_MID && !low_seen_r |=> RDATA == 8'h00;
  endproperty
  a_zero_mid: assert property (p_zero_mid) else $error("mid byte not zero before low read");

  property p_zero_high;
    @(posedge MCLK) disable iff (RESET)
      CE && RD_EN && ADDR == ADDR_STAT_HIGH && !low_seen_r |=> RDATA == 8'h00;
  endproperty
  a_zero_high: assert property (p_zero_high) else $error("high byte not zero early");

  property p_sel_write;
    @(posedge MCLK) disable iff (RESET)
      CE && WR_EN && ADDR == ADDR_STAT_SEL |=> sel_r == $past(WDATA[3:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector not written");

  property p_seed;
    @(posedge MCLK) disable iff (RESET)
      CE |=> CHECKSUM_SEED == $past(HIDDEN_CHECKSUM);
  endproperty
  a_seed: assert property (p_seed) else $error("seed does not follow checksum");

  property p_phase;
    @(posedge MCLK) disable iff (RESET)
      sel_r == SEL_PHASE |-> status_word == {20'h00000, &PHASE_OK, PHASE_OK};
  endproperty
  a_phase: assert property (p_phase) else $error("phase flags mismatch");

  property p_unused_code;
    @(posedge MCLK) disable iff (RESET)
      sel_r == 4'h7 || sel_r > SEL_PHASE |-> status_word == 24'h000000;
  endproperty
  a_unused_code: assert property (p_unused_code) else $error("unassigned selector not zero");

  property p_brake_rb;
    @(posedge MCLK) disable iff (RESET)
      CE && RD_EN && ADDR == ADDR_BRAKE_DUTY_HIGH |=> RDATA[6:2] == 5'h00;
  endproperty
  a_brake_rb: assert property (p_brake_rb) else $error("brake register spare bits set");

  // answer strobe follows the read strobe by exactly one enabled edge
  property p_rvalid;
    @(posedge MCLK) disable iff (RESET)
      CE |=> RVALID == $past(RD_EN);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer strobe mismatch");

  property p_cmd_read;
    @(posedge MCLK) disable iff (RESET)
      CE && RD_EN && ADDR == ADDR_CMD |=> RDATA == 8'h00;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command register read not zero");
endmodule
`default_nettype wire

// ### hw/motor_regs_pkg.sv
// shared constants for the motor status mux and control register block
package motor_regs_pkg;
  localparam logic [9:0] ADDR_STAT_LOW = 10'h205;
  localparam logic [9:0] ADDR_STAT_MID = 10'h206;
  localparam logic [9:0] ADDR_STAT_HIGH = 10'h207;
  localparam logic [9:0] ADDR_SEED = 10'h208;
  localparam logic [9:0] ADDR_CMD = 10'h300;
  localparam logic [9:0] ADDR_DUTY_LOW = 10'h301;
  localparam logic [9:0] ADDR_BRAKE_DUTY_HIGH = 10'h302;
  localparam logic [9:0] ADDR_STAT_SEL = 10'h306;
  localparam logic [7:0] CMD_WATCHDOG = 8'h00;
  localparam logic [7:0] CMD_CHECKSUM_CLR = 8'h55;
  localparam logic [7:0] CMD_LATCH_RELEASE = 8'hff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int BRAKE_BIT = 7;
  localparam logic [3:0] SEL_PERIOD = 4'h0;
  localparam logic [3:0] SEL_RPM = 4'h1;
  localparam logic [3:0] SEL_IN_DUTY = 4'h2;
  localparam logic [3:0] SEL_IN_PERIOD = 4'h3;
  localparam logic [3:0] SEL_IN_HIGH = 4'h4;
  localparam logic [3:0] SEL_TARGET = 4'h5;
  localparam logic [3:0] SEL_LOOP_DUTY = 4'h6;
  localparam logic [3:0] SEL_PHASE = 4'h8;
  localparam int TIMEBASE_KHZ = 500;
  localparam int CLOCK_KHZ = 25000;
  localparam int TICKS_PER_COUNT = 2;
  // system clock cycles per period count step: 4 us at 25 MHz = 100
  localparam int PERIOD_STEP_CYCLES = CLOCK_KHZ / TIMEBASE_KHZ * TICKS_PER_COUNT;
endpackage

// ### hw/period_counter.sv
// rotation period counter and rpm derivation
`timescale 1ns/1ps
`default_nettype none
module period_counter
  import motor_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rev_pulse,
  output logic [19:0] period_count,
  output logic [14:0] speed_rpm
);
  logic [6:0] pre_r;
  logic [19:0] run_r;
  logic step;
  assign step = (pre_r == 7'(PERIOD_STEP_CYCLES - 1));

  // prescaler: one step every two 500 kHz ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_r <= 7'h00;
    end else if (ce) begin
      pre_r <= step ? 7'h00 : pre_r + 7'h01;
    end
  end

  // running count, latched at each revolution mark; saturates on stall
  always_ff @(posedge clk) begin
    if (rst) begin
      run_r <= 20'h00000;
      period_count <= 20'h00000;
    end else if (ce) begin
      if (rev_pulse) begin
        period_count <= run_r;
        run_r <= 20'h00000;
      end else if (step && run_r != 20'hfffff) begin
        run_r <= run_r + 20'h00001;
      end
    end
  end

  // rpm = 60 / (count * 4us) = 15000000 / count; divide is combinational
  // and slow, acceptable since it only feeds a status read
  logic [23:0] quot;
  always_comb begin
    quot = 24'h000000;
    if (period_count != 20'h00000) begin
      quot = 24'(24'he4e1c0 / {4'h0, period_count});
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_rpm <= 15'h0000;
    end else if (ce) begin
      speed_rpm <= (quot > 24'h007fff) ? 15'h7fff : quot[14:0];
    end
  end
endmodule
`default_nettype wire

// ### hw/status_mux.sv
// status selector multiplexer
`timescale 1ns/1ps
`default_nettype none
module status_mux
  import motor_regs_pkg::*;
(
  input wire logic [3:0] sel,
  input wire logic [19:0] period_count,
  input wire logic [14:0] speed_rpm,
  input wire logic [9:0] in_duty,
  input wire logic [21:0] in_period,
  input wire logic [21:0] in_high,
  input wire logic [14:0] target,
  input wire logic [9:0] loop_duty,
  input wire logic [2:0] phase_ok,
  output logic [23:0] word
);
  // unused bits and unassigned codes read zero
  always_comb begin
    word = 24'h000000;
    case (sel)
      SEL_PERIOD: word = {4'h0, period_count};
      SEL_RPM: word = {9'h000, speed_rpm};
      SEL_IN_DUTY: word = {14'h0000, in_duty};
      SEL_IN_PERIOD: word = {2'h0, in_period};
      SEL_IN_HIGH: word = {2'h0, in_high};
      SEL_TARGET: word = {9'h000, target};
      SEL_LOOP_DUTY: word = {14'h0000, loop_duty};
      SEL_PHASE: word = {20'h00000, &phase_ok, phase_ok};
      default: word = 24'h000000;
    endcase
  end
endmodule
`default_nettype wire

// ### test/mcu_host_model.sv
// host microcontroller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module mcu_host_model
  import motor_regs_pkg::*;
(
  input wire logic clk,
  output logic ce,
  output logic [9:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // reads that got no answer in time; the bench counts them as mismatches
  int misses = 0;
  // bus idles with strobes low
  initial begin
    ce = 1'b1;
    addr = 10'h000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
  end
  // one write; lines flip after so stale values never look valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  // one read; ok drops when no answer within four cycles
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) begin
      @(negedge clk);
    end
    ok = (rvalid === 1'b1);
    d = rdata;
    if (!ok) begin
      misses++;
    end
  endtask
  // back-to-back burst, low byte first so the upper bytes come from one snapshot
  task automatic status_read(output logic [23:0] w, output logic ok);
    ok = 1'b1;
    @(negedge clk);
    addr = ADDR_STAT_LOW;
    rd_en = 1'b1;
    @(negedge clk);
    ok = ok & (rvalid === 1'b1);
    w[7:0] = rdata;
    addr = ADDR_STAT_MID;
    @(negedge clk);
    ok = ok & (rvalid === 1'b1);
    w[15:8] = rdata;
    addr = ADDR_STAT_HIGH;
    @(negedge clk);
    ok = ok & (rvalid === 1'b1);
    w[23:16] = rdata;
    rd_en = 1'b0;
    addr = ~ADDR_STAT_HIGH;
    if (!ok) begin
      misses++;
    end
  endtask
  // freeze or run the block through its clock enable
  task automatic set_ce(input logic run);
    ce = run;
  endtask
  // periodic watchdog service
  task automatic kick();
    wr(ADDR_CMD, CMD_WATCHDOG);
  endtask
endmodule
`default_nettype wire

// ### test/motor_status_mux_control_regs_tb.sv
// self-checking bench for the motor command and status registers
`timescale 1ns/1ps
`default_nettype none
module motor_status_mux_control_regs_tb
  import motor_regs_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic rev_pulse = 1'b0;
  logic [9:0] in_duty = 10'h2a5;
  logic [21:0] in_period = 22'h3abcde;
  logic [21:0] in_high = 22'h2fedcb;
  logic [14:0] target = 15'h7abc;
  logic [9:0] loop_duty = 10'h3c3;
  logic [2:0] phase_ok = 3'b101;
  logic [7:0] hidden = 8'h5a;
  logic ce, wr_en, rd_en, rvalid, wd, cc, lr, short_brake_enable;
  logic [9:0] addr, duty;
  logic [7:0] wdata, rdata, seed;
  int errors = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  always #20 mclk = ~mclk;
  mcu_host_model host (.clk(mclk), .ce(ce), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  motor_ctrl_regs DUT (.MCLK(mclk), .RESET(reset), .CE(ce), .ADDR(addr), .WR_EN(wr_en),
    .RD_EN(rd_en), .WDATA(wdata), .REV_PULSE(rev_pulse), .IN_DUTY(in_duty),
    .IN_PERIOD(in_period), .IN_HIGH(in_high), .TARGET(target), .LOOP_DUTY(loop_duty),
    .PHASE_OK(phase_ok), .HIDDEN_CHECKSUM(hidden), .RDATA(rdata), .RVALID(rvalid),
    .WATCHDOG_RESTART(wd), .CHECKSUM_CLEAR(cc), .LATCH_RELEASE(lr),
    .SHORT_BRAKE_ENABLE(short_brake_enable), .DUTY_INPUT_VALUE(duty), .CHECKSUM_SEED(seed));
  ////////////////////////////////////////////////////////////////////////////////
  // exact compare
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // compare allowing one count of phase slip between clock and time base
  task automatic chk_near(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if ((got >= exp - 1 && got <= exp + 1) !== 1'b1) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic done_test(input string name);
    $display("test %s finished", name);
  endtask
  task automatic complete_run();
    errors += host.misses;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // status word expected before any rotation was measured
  function automatic logic [23:0] exp_word(input logic [3:0] s);
    case (s)
      SEL_IN_DUTY: exp_word = {14'h0, in_duty};
      SEL_IN_PERIOD: exp_word = {2'h0, in_period};
      SEL_IN_HIGH: exp_word = {2'h0, in_high};
      SEL_TARGET: exp_word = {9'h0, target};
      SEL_LOOP_DUTY: exp_word = {14'h0, loop_duty};
      SEL_PHASE: exp_word = {20'h0, &phase_ok, phase_ok};
      default: exp_word = 24'h0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard, about 50000 cycles
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
  // main sequence
  initial begin
    logic [23:0] w;
    logic [7:0] d;
    logic [7:0] h;
    logic ok;
    logic [7:0] cmds [4];
    cmds = '{8'h00, 8'h55, 8'hff, 8'h12};
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    host.rd(ADDR_STAT_MID, d, ok);
    chk(d, 8'h00);
    host.rd(ADDR_STAT_HIGH, d, ok);
    chk(d, 8'h00);
    host.rd(ADDR_BRAKE_DUTY_HIGH, d, ok);
    chk({ok, d, short_brake_enable}, {1'b1, CTRL_RESET, 1'b0});
    done_test("reset");
    foreach (cmds[i]) begin
      host.wr(ADDR_CMD, cmds[i]);
      chk({wd, cc, lr}, {cmds[i] == 8'h00, cmds[i] == 8'h55, cmds[i] == 8'hff});
    end
    host.kick();
    chk(wd, 1'b1);
    @(negedge mclk);
    chk({wd, cc, lr}, 3'b000);
    host.rd(ADDR_CMD, d, ok);
    chk(d, 8'h00);
    done_test("command");
    host.wr(ADDR_DUTY_LOW, 8'hc3);
    host.wr(ADDR_BRAKE_DUTY_HIGH, 8'hff);
    host.set_ce(1'b0);
    host.wr(ADDR_DUTY_LOW, 8'h11);
    host.set_ce(1'b1);
    @(negedge mclk);
    chk({short_brake_enable, duty}, {1'b1, 10'h3c3});
    host.rd(ADDR_BRAKE_DUTY_HIGH, d, ok);
    chk(d, 8'h83);
    host.wr(ADDR_BRAKE_DUTY_HIGH, 8'h7e);
    @(negedge mclk);
    chk({short_brake_enable, duty}, {1'b0, 10'h2c3});
    host.rd(10'h3ff, d, ok);
    chk(d, 8'h00);
    done_test("control");
    for (int i = 0; i < 16; i++) begin
      host.wr(ADDR_STAT_SEL, i[7:0]);
      host.status_read(w, ok);
      chk(ok, 1'b1);
      chk(w, exp_word(i[3:0]));
    end
    // selector moved between low and upper reads
    host.wr(ADDR_STAT_SEL, 8'h03);
    host.rd(ADDR_STAT_LOW, d, ok);
    host.wr(ADDR_STAT_SEL, 8'h04);
    host.rd(ADDR_STAT_MID, d, ok);
    host.rd(ADDR_STAT_HIGH, h, ok);
    chk({h, d}, {2'h0, in_period[21:8]});
    host.rd(ADDR_SEED, d, ok);
    chk({d, seed}, {hidden, hidden});
    done_test("status");
    // two revolutions 5000 cycles apart give 50 steps of 100 cycles
    host.wr(ADDR_STAT_SEL, {4'h0, SEL_PERIOD});
    for (int k = 0; k < 2; k++) begin
      rev_pulse = 1'b1;
      @(negedge mclk);
      rev_pulse = 1'b0;
      repeat (4999) @(negedge mclk);
    end
    rev_pulse = 1'b1;
    @(negedge mclk);
    rev_pulse = 1'b0;
    host.status_read(w, ok);
    chk_near(w, 24'd50);
    host.wr(ADDR_STAT_SEL, {4'h0, SEL_RPM});
    host.status_read(w, ok);
    chk(w, 24'h007fff);
    done_test("rotation");
    complete_run();
  end
endmodule
`default_nettype wire
